// ===== hdl/bsl_exec.v
// Purpose: executes skips, flag branches, pointer loads and pointer stores
// Assumes: program words, flag register and i/o reads answer in the same cycle
// Notes:   data memory read data is taken in the cycle that dm_rd_o is high
`timescale 1ns/1ps
`include "bsl_defs.vh"

module bsl_exec #(
  parameter PC_W = 16
) (
  input  wire            mclk_i,
  input  wire            sys_rst_i,
  input  wire            psel_i,
  input  wire            penable_i,
  input  wire            pwrite_i,
  input  wire [7:0]      paddr_i,
  input  wire [31:0]     pwdata_i,
  output wire [31:0]     prdata_o,
  output wire            pready_o,
  output wire            pslverr_o,
  output wire [PC_W-1:0] pc_o,
  input  wire [15:0]     ins_word_i,
  input  wire [15:0]     ins_next_i,
  input  wire [7:0]      flags_i,
  output wire [4:0]      io_addr_o,
  input  wire [7:0]      io_rdata_i,
  output wire [15:0]     dm_addr_o,
  output wire            dm_rd_o,
  output wire            dm_wr_o,
  output wire [7:0]      dm_wdata_o,
  input  wire [7:0]      dm_rdata_i,
  output wire            retire_o
);
  localparam ST_EXEC = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_LOAD = 2'h2;

  // opcode compare, used for every instruction match except the skip source test
  function is_op;
    input [15:0] w;
    input [15:0] m;
    input [15:0] v;
    begin
      is_op = ((w & m) == v);
    end
  endfunction

  // instructions that carry a second program word
  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = is_op(w, `BSL_M_TWO_A, `BSL_V_TWO_A) |
                    is_op(w, `BSL_M_TWO_B, `BSL_V_TWO_B);
    end
  endfunction

  reg  [1:0]      state_q, state_d;
  reg  [1:0]      wait_q, wait_d;
  reg  [PC_W-1:0] pc_q, pc_d;
  reg             run_q;
  reg             unsup_q;
  reg             taken_q, taken_d;
  reg  [31:0]     retired_q;
  reg  [4:0]      dbg_sel_q;
  reg  [31:0]     prdata_q;
  reg             pslverr_q;
  reg  [15:0]     dm_addr_q, dm_addr_d;
  reg             dm_rd_q, dm_rd_d;
  reg             dm_wr_q, dm_wr_d;
  reg  [7:0]      dm_wdata_q;
  reg  [4:0]      ld_dst_q;
  reg  [PC_W-1:0] ld_pc_q, ld_pc_d;
  reg             retire_q, retire_d;

  reg             ptr_we;
  reg  [1:0]      ptr_sel;
  reg  [15:0]     ptr_new;
  reg             unsup_set;
  reg             cond;
  reg  [15:0]     ptr_cur;

  wire [4:0]      rf_idx;
  wire [7:0]      rf_data;
  wire [7:0]      dbg_data;
  wire [15:0]     ptr_x, ptr_y, ptr_z;
  wire [2:0]      bit_sel;
  wire [2:0]      flg_sel;
  wire [PC_W-1:0] br_ofs;
  wire [5:0]      ld_disp;
  wire [1:0]      skip_cyc;
  wire [PC_W-1:0] skip_len;
  wire            exec_en;
  wire            apb_wr, apb_setup;
  wire            flg_val;

  // operand fields
  assign rf_idx   = ins_word_i[8:4];
  assign bit_sel  = ins_word_i[2:0];
  assign flg_sel  = ins_word_i[2:0];
  assign io_addr_o = ins_word_i[7:3];
  assign ld_disp  = {ins_word_i[13], ins_word_i[11:10], ins_word_i[2:0]};
  // signed word displacement, sign bit replicated over the pc width
  assign br_ofs   = {{(PC_W-7){ins_word_i[9]}}, ins_word_i[9:3]};
  // a two-word victim costs one extra cycle and one extra pc step
  assign skip_cyc = is_two_word(ins_next_i) ? `BSL_CYC_SKIP2 : `BSL_CYC_SKIP1;
  assign skip_len = is_two_word(ins_next_i) ? {{(PC_W-2){1'b0}}, 2'h3} : {{(PC_W-2){1'b0}}, 2'h2};
  assign exec_en  = run_q & (state_q == ST_EXEC);

  // signed test flag taken as n xor v so stale s values cannot mislead
  assign flg_val = (flg_sel == `BSL_FLG_S) ?
                   (flags_i[`BSL_FLG_N] ^ flags_i[`BSL_FLG_V]) :
                   flags_i[flg_sel];

  bsl_regfile u_rf (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .rd_addr_i  (rf_idx),
    .rd_data_o  (rf_data),
    .dbg_addr_i (dbg_sel_q),
    .dbg_data_o (dbg_data),
    .wr_en_i    (state_q == ST_LOAD),
    .wr_addr_i  (ld_dst_q),
    .wr_data_i  (dm_rdata_i),
    .ptr_we_i   (ptr_we),
    .ptr_sel_i  (ptr_sel),
    .ptr_data_i (ptr_new),
    .ptr_x_o    (ptr_x),
    .ptr_y_o    (ptr_y),
    .ptr_z_o    (ptr_z)
  );

  // decode and next state; nothing here ever drives the flag register
  always @* begin
    state_d   = state_q;
    wait_d    = wait_q;
    pc_d      = pc_q;
    taken_d   = taken_q;
    dm_addr_d = dm_addr_q;
    dm_rd_d   = 1'b0;
    dm_wr_d   = 1'b0;
    ld_pc_d   = ld_pc_q;
    retire_d  = 1'b0;
    ptr_we    = 1'b0;
    ptr_sel   = 2'h0;
    ptr_new   = 16'h0000;
    unsup_set = 1'b0;
    cond      = 1'b0;
    ptr_cur   = ptr_x;
    case (state_q)
      ST_EXEC: begin
        if (run_q) begin
          pc_d = pc_q + 1'b1;
          if (is_op(ins_word_i, `BSL_M_SKREG, `BSL_V_SKREG) |
              is_op(ins_word_i, `BSL_M_SKIO, `BSL_V_SKIO0) |
              is_op(ins_word_i, `BSL_M_SKIO, `BSL_V_SKIO1)) begin
            if (ins_word_i[15:12] == 4'hF) begin
              cond = rf_data[bit_sel];
            end else if (ins_word_i[9]) begin
              cond = io_rdata_i[bit_sel];
            end else begin
              cond = ~io_rdata_i[bit_sel];
            end
            taken_d = cond;
            if (cond) begin
              pc_d    = pc_q + skip_len;
              wait_d  = skip_cyc;
              state_d = ST_WAIT;
            end else begin
              retire_d = 1'b1;
            end
          end else if (is_op(ins_word_i, `BSL_M_BRF, `BSL_V_BRF1) |
                       is_op(ins_word_i, `BSL_M_BRF, `BSL_V_BRF0)) begin
            // bit 10 low selects the flag-set form
            cond    = ins_word_i[10] ? ~flg_val : flg_val;
            taken_d = cond;
            if (cond) begin
              pc_d    = pc_q + br_ofs + 1'b1;
              wait_d  = `BSL_CYC_TAKEN;
              state_d = ST_WAIT;
            end else begin
              retire_d = 1'b1;
            end
          end else if (is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDDIR)) begin
            dm_addr_d = ins_next_i;
            dm_rd_d   = 1'b1;
            ld_pc_d   = pc_q + 2'h2;
            pc_d      = pc_q;
            state_d   = ST_LOAD;
          end else if (is_op(ins_word_i, `BSL_M_LDOFS, `BSL_V_LDOFS)) begin
            // plain y and z loads are the zero-displacement case
            ptr_cur   = ins_word_i[3] ? ptr_y : ptr_z;
            dm_addr_d = ptr_cur + {10'h000, ld_disp};
            dm_rd_d   = 1'b1;
            ld_pc_d   = pc_q + 1'b1;
            pc_d      = pc_q;
            state_d   = ST_LOAD;
          end else if (is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDX) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDXI) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDXD) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDYI) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDYD) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDZI) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_LDZD)) begin
            ptr_sel = (ins_word_i[3:2] == 2'h3) ? 2'h0 :
                      ins_word_i[3] ? 2'h1 : 2'h2;
            ptr_cur = (ptr_sel == 2'h0) ? ptr_x : (ptr_sel == 2'h1) ? ptr_y : ptr_z;
            if (ins_word_i[1]) begin
              // new address is used for the access itself
              ptr_new   = ptr_cur - 1'b1;
              dm_addr_d = ptr_cur - 1'b1;
              ptr_we    = 1'b1;
            end else begin
              dm_addr_d = ptr_cur;
              ptr_new   = ptr_cur + 1'b1;
              ptr_we    = ins_word_i[0];
            end
            dm_rd_d = 1'b1;
            ld_pc_d = pc_q + 1'b1;
            pc_d    = pc_q;
            state_d = ST_LOAD;
          end else if (is_op(ins_word_i, `BSL_M_LDST, `BSL_V_STX) |
                       is_op(ins_word_i, `BSL_M_LDST, `BSL_V_STXI)) begin
            dm_addr_d = ptr_x;
            dm_wr_d   = 1'b1;
            ptr_sel   = 2'h0;
            ptr_new   = ptr_x + 1'b1;
            ptr_we    = ins_word_i[0];
            wait_d    = 2'h1;
            state_d   = ST_WAIT;
          end else begin
            // outside this unit's set: stepped over as a one-cycle no-op
            unsup_set = 1'b1;
            if (is_two_word(ins_word_i)) begin
              pc_d = pc_q + 2'h2;
            end
            retire_d = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        wait_d = wait_q - 1'b1;
        if (wait_q == 2'h1) begin
          state_d  = ST_EXEC;
          retire_d = 1'b1;
        end
      end
      ST_LOAD: begin
        // byte is written to the destination at the end of this second cycle
        pc_d     = ld_pc_q;
        state_d  = ST_EXEC;
        retire_d = 1'b1;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  // execution registers
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q    <= ST_EXEC;
      wait_q     <= 2'h0;
      pc_q       <= `BSL_PC_RST;
      taken_q    <= 1'b0;
      dm_addr_q  <= 16'h0000;
      dm_rd_q    <= 1'b0;
      dm_wr_q    <= 1'b0;
      dm_wdata_q <= 8'h00;
      ld_dst_q   <= 5'h00;
      ld_pc_q    <= `BSL_PC_RST;
      retire_q   <= 1'b0;
      retired_q  <= 32'h0000_0000;
    end else begin
      state_q   <= state_d;
      wait_q    <= wait_d;
      taken_q   <= taken_d;
      dm_addr_q <= dm_addr_d;
      dm_rd_q   <= dm_rd_d;
      dm_wr_q   <= dm_wr_d;
      ld_pc_q   <= ld_pc_d;
      retire_q  <= retire_d;
      if (exec_en) begin
        dm_wdata_q <= rf_data;
        ld_dst_q   <= rf_idx;
      end
      if (retire_d) begin
        retired_q <= retired_q + 1'b1;
      end
      // software pc writes win only while the core is halted
      if (apb_wr && (paddr_i == `BSL_OFS_PC) && !run_q) begin
        pc_q <= pwdata_i[PC_W-1:0];
      end else begin
        pc_q <= pc_d;
      end
    end
  end

  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr    = psel_i & penable_i & pwrite_i;

  // control registers; sticky unsupported bit, a new event beats the clear
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q     <= 1'b0;
      unsup_q   <= 1'b0;
      dbg_sel_q <= 5'h00;
    end else begin
      if (apb_wr && (paddr_i == `BSL_OFS_CTRL)) begin
        run_q <= pwdata_i[`BSL_CTRL_RUN];
      end
      if (apb_wr && (paddr_i == `BSL_OFS_DBG_SEL)) begin
        dbg_sel_q <= pwdata_i[4:0];
      end
      if (unsup_set) begin
        unsup_q <= 1'b1;
      end else if (apb_wr && (paddr_i == `BSL_OFS_STAT) && pwdata_i[`BSL_STAT_UNSUP]) begin
        unsup_q <= 1'b0;
      end
    end
  end

  // read data captured in the setup cycle so the access phase needs no wait
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= 1'b0;
      case (paddr_i)
        `BSL_OFS_CTRL:     prdata_q <= {31'h0000_0000, run_q};
        `BSL_OFS_PC:       prdata_q <= {{(32-PC_W){1'b0}}, pc_q};
        `BSL_OFS_STAT:     prdata_q <= {26'h000_0000, taken_q, unsup_q, 2'h0, state_q};
        `BSL_OFS_RETIRED:  prdata_q <= retired_q;
        `BSL_OFS_DBG_SEL:  prdata_q <= {27'h000_0000, dbg_sel_q};
        `BSL_OFS_DBG_DATA: prdata_q <= {24'h00_0000, dbg_data};
        default: begin
          prdata_q  <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end

  assign prdata_o   = prdata_q;
  assign pready_o   = 1'b1;
  assign pslverr_o  = pslverr_q & psel_i & penable_i;
  assign pc_o       = pc_q;
  assign dm_addr_o  = dm_addr_q;
  assign dm_rd_o    = dm_rd_q;
  assign dm_wr_o    = dm_wr_q;
  assign dm_wdata_o = dm_wdata_q;
  assign retire_o   = retire_q;
endmodule

// ===== hdl/bsl_regfile.v
// Purpose: 32 x 8 general register file with pointer pair port
// Assumes: reads are combinational, writes land on the rising edge
// Notes:   pointer pairs sit at registers 26/27, 28/29, 30/31
`timescale 1ns/1ps
module bsl_regfile (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire [4:0]  rd_addr_i,
  output wire [7:0]  rd_data_o,
  input  wire [4:0]  dbg_addr_i,
  output wire [7:0]  dbg_data_o,
  input  wire        wr_en_i,
  input  wire [4:0]  wr_addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        ptr_we_i,
  input  wire [1:0]  ptr_sel_i,
  input  wire [15:0] ptr_data_i,
  output wire [15:0] ptr_x_o,
  output wire [15:0] ptr_y_o,
  output wire [15:0] ptr_z_o
);
  reg  [7:0] regs_q [0:31];
  wire [4:0] ptr_lo;
  integer    i;

  assign ptr_lo = (ptr_sel_i == 2'h0) ? 5'h1A : (ptr_sel_i == 2'h1) ? 5'h1C : 5'h1E;

  // read ports
  assign rd_data_o  = regs_q[rd_addr_i];
  assign dbg_data_o = regs_q[dbg_addr_i];
  assign ptr_x_o    = {regs_q[27], regs_q[26]};
  assign ptr_y_o    = {regs_q[29], regs_q[28]};
  assign ptr_z_o    = {regs_q[31], regs_q[30]};

  // byte port and pointer port; the core never uses both in one cycle
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      if (wr_en_i) begin
        regs_q[wr_addr_i] <= wr_data_i;
      end
      if (ptr_we_i) begin
        regs_q[ptr_lo]        <= ptr_data_i[7:0];
        regs_q[ptr_lo | 5'h01] <= ptr_data_i[15:8];
      end
    end
  end
endmodule

// ===== shared/bsl_defs.vh
// Purpose: constants for the branch/skip/load/store execution block
// Assumes: 16-bit instruction words, 8-bit data, 16-bit data addresses
// Notes:   opcode masks are applied as (word & mask) == value
`ifndef BSL_DEFS_VH
`define BSL_DEFS_VH

// apb register byte offsets
`define BSL_OFS_CTRL     8'h00
`define BSL_OFS_PC       8'h04
`define BSL_OFS_STAT     8'h08
`define BSL_OFS_RETIRED  8'h0C
`define BSL_OFS_DBG_SEL  8'h10
`define BSL_OFS_DBG_DATA 8'h14

// field positions and reset values
`define BSL_CTRL_RUN     0
`define BSL_STAT_UNSUP   4
`define BSL_STAT_TAKEN   5
`define BSL_PC_RST       16'h0000

// flag register bit positions
`define BSL_FLG_C 3'h0
`define BSL_FLG_Z 3'h1
`define BSL_FLG_N 3'h2
`define BSL_FLG_V 3'h3
`define BSL_FLG_S 3'h4
`define BSL_FLG_H 3'h5
`define BSL_FLG_T 3'h6
`define BSL_FLG_I 3'h7

// timing counts in cycles
`define BSL_CYC_TAKEN    2'h1
`define BSL_CYC_SKIP1    2'h1
`define BSL_CYC_SKIP2    2'h2

// opcode masks and values
`define BSL_M_SKREG  16'hFE08
`define BSL_V_SKREG  16'hFE00
`define BSL_M_SKIO   16'hFF00
`define BSL_V_SKIO0  16'h9900
`define BSL_V_SKIO1  16'h9B00
`define BSL_M_BRF    16'hFC00
`define BSL_V_BRF1   16'hF000
`define BSL_V_BRF0   16'hF400
`define BSL_M_LDST   16'hFE0F
`define BSL_V_LDX    16'h900C
`define BSL_V_LDXI   16'h900D
`define BSL_V_LDXD   16'h900E
`define BSL_V_LDYI   16'h9009
`define BSL_V_LDYD   16'h900A
`define BSL_V_LDZI   16'h9001
`define BSL_V_LDZD   16'h9002
`define BSL_V_LDDIR  16'h9000
`define BSL_V_STX    16'h920C
`define BSL_V_STXI   16'h920D
`define BSL_M_LDOFS  16'hD200
`define BSL_V_LDOFS  16'h8000
`define BSL_M_TWO_A  16'hFC0F
`define BSL_V_TWO_A  16'h9000
`define BSL_M_TWO_B  16'hFE0C
`define BSL_V_TWO_B  16'h940C

`endif

// ===== verif/bsl_exec_properties.sv
// Purpose: port-level timing and flow checks for the execution block
// Assumes: program words follow pc_o in the same cycle
// Notes:   register-bit skips need file contents, so the bench scores those
`timescale 1ns/1ps
module bsl_exec_chk #(
  parameter PC_W = 16
) (
  input wire            mclk_i,
  input wire            sys_rst_i,
  input wire [PC_W-1:0] pc_o,
  input wire [15:0]     ins_word_i,
  input wire [15:0]     ins_next_i,
  input wire [7:0]      flags_i,
  input wire [7:0]      io_rdata_i,
  input wire            dm_rd_o,
  input wire            dm_wr_o,
  input wire            retire_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // decode of the word at pc; s=4 selects negative xor overflow
  wire            brf_w = ins_word_i[15:11] == 5'h1E;
  wire [2:0]      s_w   = ins_word_i[2:0];
  wire            fl_w  = (s_w == 3'h4) ? (flags_i[2] ^ flags_i[3]) : flags_i[s_w];
  wire            tk_w  = brf_w && (fl_w != ins_word_i[10]);
  wire [PC_W-1:0] k_w   = {{(PC_W-7){ins_word_i[9]}}, ins_word_i[9:3]};
  wire            sio_w = (ins_word_i & 16'hFD00) == 16'h9900;
  wire            sk_w  = sio_w && (io_rdata_i[s_w] == ins_word_i[9]);
  wire            two_w = ((ins_next_i & 16'hFC0F) == 16'h9000)
                       || ((ins_next_i & 16'hFE0C) == 16'h940C);
  wire [PC_W-1:0] nx_w  = pc_o + PC_W'(tk_w ? k_w + 1 : (sk_w ? (two_w ? 3 : 2) : 1));

  AST_BR_FLAG_SET: assert property ($changed(pc_o) && $past(brf_w && !ins_word_i[10])
    |-> pc_o == $past(nx_w)) else $error("flag-set branch target wrong");
  AST_BR_FLAG_CLR: assert property ($changed(pc_o) && $past(brf_w && ins_word_i[10])
    |-> pc_o == $past(nx_w)) else $error("flag-clear branch target wrong");
  AST_BR_SIGNED: assert property ($changed(pc_o) && $past(brf_w && s_w == 3'h4)
    |-> pc_o == $past(nx_w)) else $error("signed branch ignores n xor v");
  AST_BR_TAKEN_CYC: assert property ($changed(pc_o) && $past(tk_w)
    |-> !retire_o ##1 retire_o) else $error("taken branch not two cycles");
  AST_BR_IDLE_CYC: assert property ($changed(pc_o) && $past(brf_w && !tk_w)
    |-> retire_o) else $error("untaken branch not one cycle");
  AST_SKIP_IO_ZERO: assert property ($changed(pc_o) && $past(sio_w && !ins_word_i[9])
    |-> pc_o == $past(nx_w)) else $error("io-zero skip wrong");
  AST_SKIP_IO_ONE: assert property ($changed(pc_o) && $past(sio_w && ins_word_i[9])
    |-> pc_o == $past(nx_w)) else $error("io-one skip wrong");
  AST_SKIP_TWO_WORD: assert property ($changed(pc_o) && $past(sk_w && two_w)
    |-> !retire_o ##1 !retire_o ##1 retire_o) else $error("long skip not three cycles");
  AST_LOAD_CYC: assert property (dm_rd_o |-> !dm_wr_o ##1 (retire_o && !dm_rd_o))
    else $error("load not two cycles");
  AST_STORE_CYC: assert property (dm_wr_o |=> retire_o && !dm_wr_o)
    else $error("store not two cycles");
endmodule

bind bsl_exec bsl_exec_chk #(.PC_W(PC_W)) chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .pc_o(pc_o), .ins_word_i(ins_word_i), .ins_next_i(ins_next_i), .flags_i(flags_i),
  .io_rdata_i(io_rdata_i), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .retire_o(retire_o));

// ===== verif/bsl_mem_model.sv
// Purpose: data memory and i/o space seen by the execution block
// Assumes: 256 bytes, address bits above 7 alias
// Notes:   fill patterns are mirrored by the bench model
`timescale 1ns/1ps
module bsl_mem_model (
  input  wire        mclk_i,
  input  wire [4:0]  io_addr_i,
  output wire [7:0]  io_rdata_o,
  input  wire [15:0] dm_addr_i,
  input  wire        dm_rd_i,
  input  wire        dm_wr_i,
  input  wire [7:0]  dm_wdata_i,
  output wire [7:0]  dm_rdata_o
);
  reg     [7:0] mem_q [0:255];
  integer       i;
  // fixed fill so the bench can predict every load
  initial for (i = 0; i < 256; i = i + 1) mem_q[i] = 8'(i * 29 + 3);
  // write lands on the pulse edge
  always @(posedge mclk_i) if (dm_wr_i) mem_q[dm_addr_i[7:0]] <= dm_wdata_i;
  // idle bus shows the complement so stale data is never mistaken for a read
  assign dm_rdata_o = dm_rd_i ? mem_q[dm_addr_i[7:0]] : ~mem_q[dm_addr_i[7:0]];
  assign io_rdata_o = ({3'h0, io_addr_i} * 8'h4B) ^ 8'h96;
endmodule

// ===== verif/testbench.sv
// Purpose: self-checking bench for the execution block
// Assumes: program words served from a 256-word array indexed by pc_o
// Notes:   model effects commit at retire, so a halt never leaves it ahead
`timescale 1ns/1ps
module testbench;
  reg         mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, er_v;
  reg  [7:0]  paddr_i, flags_i;
  reg  [31:0] pwdata_i, rd_v;
  reg  [15:0] epc;
  reg  [15:0] prog [0:255];
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, dm_rd_o, dm_wr_o, retire_o;
  wire [15:0] pc_o, dm_addr_o;
  wire [4:0]  io_addr_o;
  wire [7:0]  io_rdata_i, dm_rdata_i, dm_wdata_o;
  wire [15:0] ins_word_i = prog[pc_o[7:0]];
  wire [15:0] ins_next_i = prog[pc_o[7:0] + 8'h01];
  integer     fail_count = 0, total_checks = 0, cyc = 0, nret = 0, i;
  integer     pd = -1, pp = -1, pm = -1, pv, pn, pmv;
  integer     rf [0:31];
  integer     mem [0:255];
  integer     qa [$];
  integer     qd [$];

  bsl_exec dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pc_o(pc_o),
    .ins_word_i(ins_word_i), .ins_next_i(ins_next_i), .flags_i(flags_i),
    .io_addr_o(io_addr_o), .io_rdata_i(io_rdata_i), .dm_addr_o(dm_addr_o),
    .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o),
    .dm_rdata_i(dm_rdata_i), .retire_o(retire_o));
  bsl_mem_model mem_u (.mclk_i(mclk_i), .io_addr_i(io_addr_o), .io_rdata_o(io_rdata_i),
    .dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o),
    .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i));

  // free-running core clock
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end

  task check(input [31:0] seen, input [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // apb master: setup, then hold access until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd_v = prdata_o;
    er_v = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask

  // random instruction mix; pointer loads, offset loads and stores keep off the pointer registers, direct loads do not
  function automatic [15:0] gen();
    reg [15:0] r;
    reg [27:0] lm;
    reg [4:0]  d;
    r = $urandom;
    d = r[8:4] % 26;
    lm = 28'hCDE9A12 >> (4 * (r[11:9] % 7));
    case (r[3:0] % 8)
      0, 1: gen = {5'h1E, r[10:0]};
      2: gen = {7'h7F, r[8:4], 1'b0, r[2:0]};
      3: gen = {6'h26, r[9], 1'b1, r[7:0]};
      4: gen = {7'h48, d, lm[3:0]};
      5: gen = {2'h2, r[15], 1'b0, r[14:13], 1'b0, d, r[12], r[2:0]};
      6: gen = {7'h48, r[8:4], 4'h0};
      default: gen = {7'h49, d, 3'h6, r[9]};
    endcase
  endfunction

  // predict the next instruction; effects wait until it retires
  task automatic step();
    reg [15:0] w, a;
    integer    b, sk, nx;
    w = prog[epc[7:0]];
    nx = 1;
    sk = 0;
    b = w[3:2] == 3 ? 26 : (w[3:2] == 2 ? 28 : 30);
    a = {rf[b+1][7:0], rf[b][7:0]};
    if (w[15:11] == 5'h1E) begin
      sk = w[2:0] == 4 ? flags_i[2] ^ flags_i[3] : flags_i[w[2:0]];
      if (sk != w[10]) nx = {{9{w[9]}}, w[9:3]} + 1;
      sk = 0;
    end else if (w[15:9] == 7'h7F) sk = (rf[w[8:4]] >> w[2:0]) & 1;
    else if ((w & 16'hFD00) == 16'h9900)
      sk = (((w[7:3] * 75 ^ 150) >> w[2:0]) & 1) == w[9];
    else if ((w & 16'hD200) == 16'h8000) begin
      b = w[3] ? 28 : 30;
      a = {rf[b+1][7:0], rf[b][7:0]} + {w[13], w[11:10], w[2:0]};
      pd = w[8:4];
    end else if (w[15:10] == 6'h24) begin
      if (w[3:0] == 0) begin
        a = prog[epc[7:0] + 8'h01];
        nx = 2;
      end else begin
        if (w[1:0] == 2) a = a - 1;
        if (w[1:0] != 0) begin
          pp = b;
          pn = w[1:0] == 1 ? a + 1 : a;
        end
      end
      if (w[9]) begin
        pm = a[7:0];
        pmv = rf[w[8:4]];
        qd.push_back(pmv);
      end else pd = w[8:4];
    end
    if (pd >= 0 || pm >= 0) qa.push_back({w[9], a});
    if (pd >= 0) pv = mem[a[7:0]];
    // only skips use this; the index wraps the way pc_o does
    w = prog[epc[7:0] + 8'h01];
    if (sk) nx = ((w & 16'hFC0F) == 16'h9000 || (w & 16'hFE0C) == 16'h940C) ? 3 : 2;
    epc = epc + nx;
  endtask

  // score every retire and data memory pulse; cut a hang short
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (retire_o === 1'b1) begin
      nret = nret + 1;
      if (pd >= 0) rf[pd] = pv;
      if (pp >= 0) begin
        rf[pp] = pn & 255;
        rf[pp+1] = (pn >> 8) & 255;
      end
      if (pm >= 0) mem[pm] = pmv;
      pd = -1; pp = -1; pm = -1;
      check(pc_o, epc, "pc");
      step();
      flags_i <= $urandom;
    end
    if (dm_rd_o === 1'b1 || dm_wr_o === 1'b1) begin
      check({dm_wr_o, dm_addr_o}, qa.pop_front(), "dm addr");
      if (dm_wr_o) check(dm_wdata_o, qd.pop_front(), "dm data");
    end
    // runaway guard last, so nothing in this pass follows the finish
    if (cyc > 20000) begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  initial begin
    sys_rst_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0; pwdata_i = 0;
    i = $urandom(72855);
    flags_i = $urandom;
    for (i = 0; i < 256; i = i + 1) begin
      mem[i] = (i * 29 + 3) & 255;
      if (i < 32) rf[i] = 0;
      prog[i] = (i > 0 && prog[i-1][15:9] == 7'h48 && prog[i-1][3:0] == 0)
                ? $urandom & 255 : gen();
    end
    prog[0] = 16'h0000; // harmless word under the reset pc
    prog[16] = 16'h0000; // unsupported word opens the run and sets the sticky flag
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 0;
    // reset values, then an unmapped offset
    for (i = 0; i < 7; i = i + 1) begin
      apb(0, 4 * i, 0);
      check(rd_v, 0, "reset read");
      check(er_v, i == 6, "slverr");
    end
    apb(1, 8'h04, 32'h10);
    apb(0, 8'h04, 0);
    check(rd_v, 32'h10, "pc write");
    $display("test registers done");
    epc = 16'h0010;
    step();
    apb(1, 8'h00, 1);
    apb(1, 8'h04, 32'h55); // refused while running; a jump would trip the pc checks
    while (nret < 400) @(posedge mclk_i);
    apb(1, 8'h00, 0);
    repeat (4) @(posedge mclk_i);
    $display("test program done");
    apb(0, 8'h0C, 0);
    check(rd_v, nret, "retired");
    // sticky unsupported bit is set, state is idle; writing one clears it
    apb(0, 8'h08, 0);
    check(rd_v & 32'h13, 32'h10, "unsup set");
    apb(1, 8'h08, 32'h10);
    apb(0, 8'h08, 0);
    check(rd_v & 32'h13, 32'h00, "unsup clear");
    for (i = 0; i < 32; i = i + 1) begin
      apb(1, 8'h10, i);
      apb(0, 8'h14, 0);
      check(rd_v, rf[i], "reg");
    end
    $display("test register dump done");
    summarize();
  end
endmodule
